// >>> hw/meter_pkg.sv
package meter_pkg;

	// Register addresses (command byte bits 5..0)
	localparam logic [5:0] ADDR_VA_ENERGY_RC = 6'h05;
	localparam logic [5:0] ADDR_LINE_VA      = 6'h06;
	localparam logic [5:0] ADDR_PERIOD       = 6'h07;
	localparam logic [5:0] ADDR_TEMP         = 6'h08;
	localparam logic [5:0] ADDR_WAVE         = 6'h09;
	localparam logic [5:0] ADDR_OPCFG        = 6'h0A;
	localparam logic [5:0] ADDR_MSEL         = 6'h0B;
	localparam logic [5:0] ADDR_WSEL         = 6'h0C;
	localparam logic [5:0] ADDR_AFS          = 6'h0D;
	localparam logic [5:0] ADDR_VAFS         = 6'h0E;
	localparam logic [5:0] ADDR_IEN          = 6'h0F;
	localparam logic [5:0] ADDR_FLAGS        = 6'h10;
	localparam logic [5:0] ADDR_FLAGS_RC     = 6'h11;
	localparam logic [5:0] ADDR_ZXTO         = 6'h12;
	localparam logic [5:0] ADDR_HCC          = 6'h13;

	// Command byte layout
	localparam int CMD_WRITE_BIT = 7;
	localparam int CMD_ADDR_LSB  = 0;
	localparam int CMD_ADDR_W    = 6;

	// Reset values
	localparam logic [7:0]  RST_OPCFG = 8'h04;
	localparam logic [7:0]  RST_MSEL  = 8'h70;
	localparam logic [7:0]  RST_WSEL  = 8'h00;
	localparam logic [7:0]  RST_AFS   = 8'h3F;
	localparam logic [7:0]  RST_VAFS  = 8'h3F;
	localparam logic [15:0] RST_IEN   = 16'h0000;
	localparam logic [15:0] RST_ZXTO  = 16'hFFFF;
	localparam logic [15:0] RST_HCC   = 16'hFFFF;

	// Field positions
	localparam int VAFS_LINE_LSB  = 0;
	localparam int VAFS_TOTAL_LSB = 3;
	localparam int MSEL_PHASE_LSB = 0;
	localparam int MSEL_ZXEN_LSB  = 4;
	localparam int WSEL_SRC_LSB   = 0;

	// Interrupt flag positions
	localparam int FLAG_ZX_TO_LSB = 0;
	localparam int FLAG_LINE_DONE = 3;
	localparam int FLAG_WAVE      = 4;
	localparam int FLAG_TEMP      = 5;

	// Transfer lengths in bytes
	localparam logic [1:0] LEN_24 = 2'd3;
	localparam logic [1:0] LEN_16 = 2'd2;
	localparam logic [1:0] LEN_8  = 2'd1;

	// Zero-crossing timeout scaling
	localparam longint ZX_TIMEOUT_MAX_MS = 2300;
	localparam longint CLK_PERIOD_NS     = 40;
	localparam longint ZX_TIMEOUT_STEPS  = 65535;
	localparam int     ZX_STEP_CYCLES    = int'((ZX_TIMEOUT_MAX_MS * 1000000)
		/ (CLK_PERIOD_NS * ZX_TIMEOUT_STEPS));

	typedef struct packed {
		logic [7:0] operating;
		logic [7:0] measure;
		logic [7:0] wave;
		logic [7:0] active;
		logic [7:0] apparent;
	} cfg_t;

	typedef struct packed {
		logic [2:0][23:0] va;
		logic             va_valid;
		logic [2:0]       zx;
		logic             period_tick;
		logic [7:0]       temp;
		logic             temp_valid;
		logic [5:0][23:0] wave;
		logic             wave_valid;
		logic [15:0]      ext_events;
	} dp_in_t;

	typedef struct packed {
		logic        drive;
		logic [1:0]  nbytes;
		logic [23:0] data;
	} tx_load_t;

endpackage

// >>> hw/meter_register_bank_05_12.sv
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE1 - Read at 05h returns 24-bit apparent energy, then clears accumulator.
// RULE2 - 06h holds apparent energy summed over programmed half line cycles.
// RULE3 - Low three bits of apparent formula pick phases for line energy.
// RULE4 - 07h gives 15-bit period; phase and zero-cross enables from 0Bh.
// RULE5 - 08h holds latest 8-bit temperature conversion result.
// RULE6 - 09h holds 24-bit waveform sample, source picked by 0Ch bits 2..0.
// RULE7 - 0Ah is 8-bit read/write operating config, reset 4.
// RULE8 - 0Bh is 8-bit measurement select, reset 70h.
// RULE9 - 0Ch is 8-bit waveform select, reset zero.
// RULE10 - 0Dh is 8-bit active formula select, reset 3Fh.
// RULE11 - 0Eh is 8-bit apparent formula select, reset 3Fh.
// RULE12 - 0Fh is 16-bit interrupt enable; only enabled events pull line low.
// RULE13 - 10h reads 16-bit interrupt flags without changing them.
// RULE14 - 11h reads the same flags, clearing all once read completes.
// RULE15 - 12h is 16-bit zero-cross timeout, reset FFFFh; expiry flags phase.
// RULE16 - Largest timeout setting equals 2.3 seconds.
// RULE17 - Command byte: bit 7 write, bit 6 zero, bits 5..0 address.
// RULE18 - 13h is 16-bit half-cycle count, reset FFFFh, sets line window.
// RULE19 - Status read releases interrupt from command end until data out.
// RULE20 - Writes to read-only registers are ignored.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module meter_register_bank_05_12 import meter_pkg::*; (
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire logic   sclk,
	input  wire logic   cs_n,
	input  wire logic   din,
	output logic        dout,
	output logic        dout_oe,
	output logic        irq_n_o,
	output logic        irq_n_oe,
	input  wire dp_in_t dp,
	output cfg_t        cfg
);

	typedef enum logic [2:0] {
		X_IDLE  = 3'b001,
		X_READ  = 3'b010,
		X_WRITE = 3'b100
	} xfer_t;

	typedef struct packed {
		cfg_t        cfg;
		logic [15:0] ien;
		logic [15:0] zxto;
		logic [15:0] hcc;
		logic [15:0] flags;
		logic [23:0] va_acc;
		logic [23:0] line_acc;
		logic [23:0] line_va;
		logic [15:0] hc_cnt;
		logic [14:0] period;
		logic [14:0] period_cnt;
		logic [7:0]  temp;
		logic [23:0] wave;
		logic [9:0]  tick_cnt;
		logic        tick;
		xfer_t       xfer;
		logic [5:0]  addr;
		logic        irq_hold;
		logic        irq_oe;
		logic        irq_level;
		logic        tx_valid;
		tx_load_t    tx;
	} bank_t;

	localparam bank_t BANK_RESET = '{
		cfg: '{operating: RST_OPCFG, measure: RST_MSEL, wave: RST_WSEL,
			active: RST_AFS, apparent: RST_VAFS},
		ien: RST_IEN,
		zxto: RST_ZXTO,
		hcc: RST_HCC,
		xfer: X_IDLE,
		default: '0
	};

	bank_t s_reg;
	bank_t s_next;

	logic        cmd_valid;
	logic [7:0]  cmd_byte;
	logic        word_valid;
	logic [23:0] word_data;
	logic [2:0]  zx_expired;
	logic [1:0]  phase_sel;
	logic [2:0]  zx_en;
	logic        zx_sel;
	logic [2:0]  wave_src;
	logic [15:0] events;
	logic        line_done;
	logic        clear_flags;
	logic [23:0] total_add;
	logic [23:0] line_add;
	logic [23:0] line_sum;
	logic [5:0]  cmd_addr;

	//////////////////////////////////////////////////////////////////////////
	// Serial port and zero-crossing watchdogs

	serial_port u_serial (
		.clk        (clk),
		.rst        (rst),
		.sclk       (sclk),
		.cs_n       (cs_n),
		.din        (din),
		.load       (s_reg.tx),
		.load_valid (s_reg.tx_valid),
		.cmd_valid  (cmd_valid),
		.cmd_byte   (cmd_byte),
		.word_valid (word_valid),
		.word_data  (word_data),
		.dout       (dout),
		.dout_oe    (dout_oe)
	);

	// RULE15 per-phase timeout
	for (genvar i = 0; i < 3; i++) begin : g_zx
		zx_timeout #(.W(16)) u_zx (
			.clk     (clk),
			.rst     (rst),
			.zx      (dp.zx[i]),
			.enable  (zx_en[i]),
			.tick    (s_reg.tick),
			.timeout (s_reg.zxto),
			.expired (zx_expired[i])
		);
	end

	//////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [23:0] phase_sum(
		input logic [2:0]       mask,
		input logic [2:0][23:0] va
	);
		logic [23:0] acc;
		acc = 24'h000000;
		for (int k = 0; k < 3; k++) begin
			if (mask[k]) begin
				acc = acc + va[k];
			end
		end
		return acc;
	endfunction

	function automatic logic [1:0] reg_len(input logic [5:0] a);
		case (a)
			ADDR_VA_ENERGY_RC, ADDR_LINE_VA, ADDR_WAVE: reg_len = LEN_24;
			ADDR_PERIOD, ADDR_IEN, ADDR_FLAGS, ADDR_FLAGS_RC,
			ADDR_ZXTO, ADDR_HCC: reg_len = LEN_16;
			default: reg_len = LEN_8;
		endcase
	endfunction

	function automatic logic [23:0] read_mux(
		input logic [5:0] a,
		input bank_t      b
	);
		case (a)
			ADDR_VA_ENERGY_RC: read_mux = b.va_acc;
			ADDR_LINE_VA:      read_mux = b.line_va;
			ADDR_PERIOD:       read_mux = {9'h000, b.period};
			ADDR_TEMP:         read_mux = {16'h0000, b.temp};
			ADDR_WAVE:         read_mux = b.wave;
			ADDR_OPCFG:        read_mux = {16'h0000, b.cfg.operating};
			ADDR_MSEL:         read_mux = {16'h0000, b.cfg.measure};
			ADDR_WSEL:         read_mux = {16'h0000, b.cfg.wave};
			ADDR_AFS:          read_mux = {16'h0000, b.cfg.active};
			ADDR_VAFS:         read_mux = {16'h0000, b.cfg.apparent};
			ADDR_IEN:          read_mux = {8'h00, b.ien};
			ADDR_FLAGS:        read_mux = {8'h00, b.flags};
			ADDR_FLAGS_RC:     read_mux = {8'h00, b.flags};
			ADDR_ZXTO:         read_mux = {8'h00, b.zxto};
			ADDR_HCC:          read_mux = {8'h00, b.hcc};
			default:           read_mux = 24'h000000;
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Datapath selections

	// RULE4 period phase and zero-cross enables
	assign phase_sel = (s_reg.cfg.measure[MSEL_PHASE_LSB +: 2] == 2'd3) ?
		2'd0 : s_reg.cfg.measure[MSEL_PHASE_LSB +: 2];
	assign zx_en = s_reg.cfg.measure[MSEL_ZXEN_LSB +: 3];
	assign zx_sel = dp.zx[phase_sel] & zx_en[phase_sel];
	assign wave_src = s_reg.cfg.wave[WSEL_SRC_LSB +: 3];
	assign cmd_addr = cmd_byte[CMD_ADDR_LSB +: CMD_ADDR_W];

	// RULE3 line phase choice
	assign line_add = dp.va_valid ?
		phase_sum(s_reg.cfg.apparent[VAFS_LINE_LSB +: 3], dp.va) : 24'h000000;
	assign total_add = dp.va_valid ?
		phase_sum(s_reg.cfg.apparent[VAFS_TOTAL_LSB +: 3], dp.va) : 24'h000000;
	assign line_sum = s_reg.line_acc + line_add;

	// RULE18 window ends at programmed half-cycle count
	assign line_done = zx_sel &&
		((s_reg.hc_cnt + 16'd1 >= s_reg.hcc) || (s_reg.hcc == 16'h0000));

	always_comb begin
		events = dp.ext_events;
		events[FLAG_ZX_TO_LSB +: 3] = dp.ext_events[FLAG_ZX_TO_LSB +: 3]
			| zx_expired;
		events[FLAG_LINE_DONE] = dp.ext_events[FLAG_LINE_DONE] | line_done;
		events[FLAG_WAVE] = dp.ext_events[FLAG_WAVE]
			| (dp.wave_valid && wave_src < 3'd6);
		events[FLAG_TEMP] = dp.ext_events[FLAG_TEMP] | dp.temp_valid;
	end

	//////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_next = s_reg;
		s_next.tx_valid = 1'b0;
		clear_flags = 1'b0;

		// RULE16 step so FFFFh steps span the longest timeout
		s_next.tick = 1'b0;
		if (s_reg.tick_cnt == 10'(ZX_STEP_CYCLES - 1)) begin
			s_next.tick_cnt = 10'h000;
			s_next.tick = 1'b1;
		end else begin
			s_next.tick_cnt = s_reg.tick_cnt + 10'h001;
		end

		s_next.va_acc = s_reg.va_acc + total_add;

		// RULE2 line-synchronised accumulation
		s_next.line_acc = line_sum;
		if (line_done) begin
			s_next.line_va = line_sum;
			s_next.line_acc = 24'h000000;
			s_next.hc_cnt = 16'h0000;
		end else if (zx_sel) begin
			s_next.hc_cnt = s_reg.hc_cnt + 16'h0001;
		end

		// RULE4 period measured between crossings
		if (dp.period_tick && s_reg.period_cnt != 15'h7FFF) begin
			s_next.period_cnt = s_reg.period_cnt + 15'h0001;
		end
		if (zx_sel) begin
			s_next.period = s_reg.period_cnt;
			s_next.period_cnt = 15'h0000;
		end

		// RULE5 temperature latch
		if (dp.temp_valid) begin
			s_next.temp = dp.temp;
		end

		// RULE6 waveform source select
		if (dp.wave_valid && wave_src < 3'd6) begin
			s_next.wave = dp.wave[wave_src];
		end

		if (cs_n) begin
			s_next.xfer = X_IDLE;
			s_next.irq_hold = 1'b0;
		end else if (cmd_valid) begin
			// RULE17 command decode
			s_next.addr = cmd_addr;
			s_next.tx_valid = 1'b1;
			s_next.tx.nbytes = reg_len(cmd_addr);
			if (cmd_byte[CMD_WRITE_BIT]) begin
				s_next.xfer = X_WRITE;
				s_next.tx.drive = 1'b0;
				s_next.tx.data = 24'h000000;
			end else begin
				s_next.xfer = X_READ;
				s_next.tx.drive = 1'b1;
				s_next.tx.data = read_mux(cmd_addr, s_reg);
				// RULE1 clear on read
				if (cmd_addr == ADDR_VA_ENERGY_RC) begin
					s_next.va_acc = total_add;
				end
				// RULE19 release during status read
				if (cmd_addr == ADDR_FLAGS || cmd_addr == ADDR_FLAGS_RC) begin
					s_next.irq_hold = 1'b1;
				end
			end
		end else if (word_valid) begin
			s_next.xfer = X_IDLE;
			s_next.irq_hold = 1'b0;
			if (s_reg.xfer == X_WRITE) begin
				// RULE20 read-only addresses fall to default
				case (s_reg.addr)
					// RULE7 operating config
					ADDR_OPCFG: s_next.cfg.operating = word_data[7:0];
					// RULE8 measurement select
					ADDR_MSEL:  s_next.cfg.measure = word_data[7:0];
					// RULE9 waveform select
					ADDR_WSEL:  s_next.cfg.wave = word_data[7:0];
					// RULE10 active formula
					ADDR_AFS:   s_next.cfg.active = word_data[7:0];
					// RULE11 apparent formula
					ADDR_VAFS:  s_next.cfg.apparent = word_data[7:0];
					// RULE12 interrupt enable
					ADDR_IEN:   s_next.ien = word_data[15:0];
					// RULE15 timeout setting
					ADDR_ZXTO:  s_next.zxto = word_data[15:0];
					// RULE18 half-cycle count
					ADDR_HCC:   s_next.hcc = word_data[15:0];
					default:    s_next.hcc = s_reg.hcc;
				endcase
			end else if (s_reg.xfer == X_READ) begin
				// RULE14 clear after read; RULE13 plain read keeps flags
				clear_flags = (s_reg.addr == ADDR_FLAGS_RC);
			end
		end

		// New events win over a clear in the same cycle
		s_next.flags = (clear_flags ? 16'h0000 : s_reg.flags) | events;

		// RULE12 enabled events drive the line
		s_next.irq_oe = (|(s_next.flags & s_next.ien)) & ~s_next.irq_hold;
		s_next.irq_level = 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= BANK_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign irq_n_o = s_reg.irq_level;
	assign irq_n_oe = s_reg.irq_oe;
	assign cfg = s_reg.cfg;

endmodule

// >>> hw/serial_port.sv
`timescale 1ns/100ps
module serial_port import meter_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        din,
	input  wire tx_load_t    load,
	input  wire logic        load_valid,
	output logic             cmd_valid,
	output logic [7:0]       cmd_byte,
	output logic             word_valid,
	output logic [23:0]      word_data,
	output logic             dout,
	output logic             dout_oe
);

	typedef enum logic [2:0] {
		SP_CMD  = 3'b001,
		SP_DATA = 3'b010,
		SP_DONE = 3'b100
	} sp_state_t;

	typedef struct packed {
		sp_state_t   st;
		logic        sclk_prev;
		logic [4:0]  bit_cnt;
		logic [1:0]  nbytes;
		logic        skip;
		logic [7:0]  cmd;
		logic [23:0] rx;
		logic [23:0] tx;
		logic        dout;
		logic        dout_oe;
		logic        cmd_valid;
		logic        word_valid;
	} sp_t;

	// Serial clock idles high, so the edge detector starts high as well
	localparam sp_t SP_RESET = '{st: SP_CMD, nbytes: LEN_8, sclk_prev: 1'b1,
		default: '0};

	sp_t s_reg;
	sp_t s_next;
	logic fall;
	logic rise;
	logic [23:0] aligned;

	assign fall = s_reg.sclk_prev & ~sclk;
	assign rise = ~s_reg.sclk_prev & sclk;

	always_comb begin
		case (load.nbytes)
			LEN_8:   aligned = {load.data[7:0], 16'h0000};
			LEN_16:  aligned = {load.data[15:0], 8'h00};
			default: aligned = load.data;
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.sclk_prev = sclk;
		s_next.cmd_valid = 1'b0;
		s_next.word_valid = 1'b0;
		if (cs_n) begin
			s_next.st = SP_CMD;
			s_next.bit_cnt = 5'd0;
			s_next.dout_oe = 1'b0;
			s_next.skip = 1'b0;
		end else begin
			case (s_reg.st)
				SP_CMD: begin
					if (fall) begin
						s_next.rx = {s_reg.rx[22:0], din};
						s_next.bit_cnt = s_reg.bit_cnt + 5'd1;
						if (s_reg.bit_cnt == 5'd7) begin
							s_next.cmd = {s_reg.rx[6:0], din};
							s_next.cmd_valid = 1'b1;
							s_next.rx = 24'h000000;
							s_next.bit_cnt = 5'd0;
							s_next.st = SP_DATA;
						end
					end
				end
				SP_DATA: begin
					if (load_valid) begin
						s_next.nbytes = load.nbytes;
						s_next.dout = aligned[23];
						s_next.tx = {aligned[22:0], 1'b0};
						s_next.dout_oe = load.drive;
						s_next.skip = 1'b1;
					end else if (rise) begin
						// First rising edge belongs to the bit already shown
						if (s_reg.skip) begin
							s_next.skip = 1'b0;
						end else begin
							s_next.dout = s_reg.tx[23];
							s_next.tx = {s_reg.tx[22:0], 1'b0};
						end
					end
					if (fall) begin
						s_next.rx = {s_reg.rx[22:0], din};
						s_next.bit_cnt = s_reg.bit_cnt + 5'd1;
						// Last data bit is number 8 * nbytes - 1
						if (s_reg.bit_cnt ==
							{s_reg.nbytes - 2'd1, 3'b111}) begin
							s_next.word_valid = 1'b1;
							s_next.st = SP_DONE;
						end
					end
				end
				SP_DONE: begin
					s_next.st = SP_DONE;
				end
				default: begin
					s_next.st = SP_CMD;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= SP_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cmd_valid = s_reg.cmd_valid;
	assign cmd_byte = s_reg.cmd;
	assign word_valid = s_reg.word_valid;
	assign word_data = s_reg.rx;
	assign dout = s_reg.dout;
	assign dout_oe = s_reg.dout_oe;

endmodule

// >>> hw/zx_timeout.sv
`timescale 1ns/100ps
module zx_timeout import meter_pkg::*; #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         zx,
	input  wire logic         enable,
	input  wire logic         tick,
	input  wire logic [W-1:0] timeout,
	output logic              expired
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         expired;
	} zt_t;

	zt_t s_reg;
	zt_t s_next;

	// Count down in steps; any crossing reloads the full timeout
	always_comb begin
		s_next = s_reg;
		s_next.expired = 1'b0;
		if (zx || !enable) begin
			s_next.cnt = timeout;
		end else if (tick) begin
			if (s_reg.cnt == '0) begin
				s_next.expired = 1'b1;
				s_next.cnt = timeout;
			end else begin
				s_next.cnt = s_reg.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_reg <= '{cnt: W'(RST_ZXTO), expired: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign expired = s_reg.expired;

endmodule

// >>> tb/host_model.sv
`timescale 1ns/100ps
module host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      cs_n,
	output logic      din,
	input  wire logic dout,
	input  wire logic dout_oe
);
	logic [23:0] got_data;
	event        got;

	// Serial clock idles high and stands still between frames
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// command then data
	task automatic xfer(input logic [7:0] cmd, input int nb,
		input logic [23:0] wd, output logic [23:0] rd);
		logic [31:0] sh;
		sh = {cmd, wd << (8 * (3 - nb))};
		rd = 24'h0;
		@(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int i = 0; i < 8 * (nb + 1); i++) begin
			din = sh[31 - i];
			repeat (4) @(negedge clk);
			if (i >= 8)
				rd = {rd[22:0], dout_oe ? dout : ~dout};
			sclk = 1'b0;
			repeat (4) @(negedge clk);
			sclk = 1'b1;
		end
		cs_n = 1'b1;
		din = ~din;
		if (!cmd[7]) begin
			got_data = rd;
			-> got;
		end
		repeat (4) @(negedge clk);
	endtask
endmodule

// >>> tb/meter_chk.sv
`timescale 1ns/100ps
module meter_chk import meter_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic irq_n_o,
	input wire logic irq_n_oe,
	input wire cfg_t cfg
);
	logic [3:0] since_cs;

	// Cycles since the host last held the chip selected, saturating
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			since_cs <= 4'hF;
		else if (!cs_n)
			since_cs <= 4'h0;
		else if (since_cs != 4'hF)
			since_cs <= since_cs + 4'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	reset_cfg_a:
	assert property ($fell(rst) |-> cfg == 40'h0470003F3F)
	else $error("config outputs not at reset value");
	reset_out_a:
	assert property ($fell(rst) |-> !dout_oe && !irq_n_oe && !dout)
	else $error("pins active right after reset");
	drain_low_a:
	assert property (!irq_n_o)
	else $error("interrupt data line not held low");
	oe_start_a:
	assert property ($rose(dout_oe) |-> !cs_n && !$past(cs_n, 4))
	else $error("read data driven outside a selected frame");
	oe_hold_a:
	assert property (dout_oe && !cs_n |=> dout_oe)
	else $error("read data released while still selected");
	oe_release_a:
	assert property (cs_n [*2] |-> !dout_oe)
	else $error("read data still driven after deselect");
	dout_edge_a:
	assert property ($changed(dout) && $past(dout_oe) && dout_oe
		|-> $past(sclk))
	else $error("read data moved away from a rising serial clock");
	cfg_write_a:
	assert property ($changed(cfg) |-> since_cs < 4'h8)
	else $error("config changed without a transfer");
	irq_drop_a:
	assert property ($fell(irq_n_oe) |-> since_cs < 4'h8)
	else $error("interrupt released without a transfer");
endmodule

bind meter_register_bank_05_12 meter_chk chk (.clk(clk), .rst(rst),
	.sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
	.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .cfg(cfg));

// >>> tb/meter_register_bank_05_12_tb.sv
`timescale 1ns/100ps
module meter_register_bank_05_12_tb import meter_pkg::*; ;
	logic        clk;
	logic        rst;
	logic        sclk;
	logic        cs_n;
	logic        din;
	logic        dout;
	logic        dout_oe;
	logic        irq_n_o;
	logic        irq_n_oe;
	dp_in_t      dp;
	dp_in_t      p;
	cfg_t        cfg;
	int          err_count = 0;
	int          checks_done = 0;
	int          seed;
	int          n;
	logic [15:0] v;
	logic [23:0] exp_q[$];
	logic [5:0]  adr[8] = '{6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
		6'h12, 6'h13};
	logic [15:0] rstv[8] = '{16'h0004, 16'h0070, 16'h0000, 16'h003F,
		16'h003F, 16'h0000, 16'hFFFF, 16'hFFFF};
	logic [15:0] fin[8] = '{16'h0004, 16'h0070, 16'h0000, 16'h003F,
		16'h003D, 16'h0000, 16'hFFFF, 16'h0000};

	meter_register_bank_05_12 dut (.clk(clk), .rst(rst), .sclk(sclk),
		.cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
		.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .dp(dp), .cfg(cfg));
	host_model hm (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din),
		.dout(dout), .dout_oe(dout_oe));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic int nbytes(input logic [5:0] a);
		case (a)
			6'h05, 6'h06, 6'h09: return 3;
			6'h07, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h13: return 2;
			default: return 1;
		endcase
	endfunction

	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		logic [23:0] r;
		hm.xfer({2'h2, a}, nbytes(a), d, r);
	endtask

	task automatic rd(input logic [5:0] a, input logic [23:0] e);
		logic [23:0] r;
		exp_q.push_back(e);
		hm.xfer({2'h0, a}, nbytes(a), 24'h0, r);
	endtask

	task automatic pulse(input dp_in_t d);
		dp = d;
		@(negedge clk);
		dp = '0;
		@(negedge clk);
	endtask

	// Each finished read is compared with the oldest expectation
	always @(hm.got) check(40'(hm.got_data), 40'(exp_q.pop_front()));

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 90;
		dp = '0;
		rst = 1'b1;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		check(cfg, 40'h0470003F3F);
		for (int i = 0; i < 8; i++) begin
			rd(adr[i], 24'(rstv[i]));
			v = 16'($random(seed));
			if (adr[i] == 6'h12)
				v[15] = 1'b1;
			if (nbytes(adr[i]) == 1)
				v[15:8] = 8'h00;
			wr(adr[i], 24'(v));
			rd(adr[i], 24'(v));
			if (i < 5)
				check(40'(cfg[39 - 8 * i -: 8]), 40'(v[7:0]));
			wr(adr[i], 24'(fin[i]));
		end
		check(cfg, 40'h0470003F3D);
		p = '0;
		p.temp = 8'h5A;
		p.temp_valid = 1'b1;
		pulse(p);
		wr(6'h08, 24'hFF);
		rd(6'h08, 24'h5A);
		wr(6'h20, 24'hFF);
		rd(6'h20, 24'h0);
		for (int s = 0; s < 6; s++) begin
			wr(6'h0C, 24'(s));
			p = '0;
			for (int k = 0; k < 6; k++)
				p.wave[k] = 24'($random(seed));
			p.wave_valid = 1'b1;
			pulse(p);
			rd(6'h09, p.wave[s]);
		end
		wr(6'h0C, 24'h0);
		p = '0;
		p.va = {24'h000003, 24'h000002, 24'h000001};
		p.va_valid = 1'b1;
		pulse(p);
		rd(6'h05, 24'h6);
		rd(6'h05, 24'h0);
		p = '0;
		p.zx = 3'h1;
		pulse(p);
		p = '0;
		p.period_tick = 1'b1;
		repeat (5) pulse(p);
		p = '0;
		p.va = {24'h000003, 24'h000002, 24'h000001};
		p.va_valid = 1'b1;
		pulse(p);
		p = '0;
		p.zx = 3'h1;
		pulse(p);
		rd(6'h07, 24'h5);
		rd(6'h06, 24'h4);
		rd(6'h10, 24'h38);
		rd(6'h11, 24'h38);
		rd(6'h10, 24'h0);
		check(40'(irq_n_oe), 40'h0);
		wr(6'h0F, 24'h7);
		wr(6'h12, 24'h2);
		// Disabling the crossings briefly reloads every watchdog count
		wr(6'h0B, 24'h0);
		wr(6'h0B, 24'h70);
		for (n = 0; n < 5000 && irq_n_oe !== 1'b1; n++)
			@(negedge clk);
		if (n == 5000) begin
			err_count++;
			complete_run();
		end
		fork
			rd(6'h10, 24'h7);
			begin
				repeat (80) @(negedge clk);
				check(40'(irq_n_oe), 40'h0);
			end
		join
		check(40'(irq_n_oe), 40'h1);
		wr(6'h12, 24'hFFFF);
		wr(6'h0B, 24'h0);
		wr(6'h0B, 24'h70);
		rd(6'h11, 24'h7);
		check(40'(irq_n_oe), 40'h0);
		complete_run();
	end
endmodule
